/* File: verilog/stream_buffer_pkg.sv */
// Register map, field layout and reset values of the stream buffer address block.
// Assumes a 32-bit APB master on the single system clock.
package stream_buffer_pkg;
   localparam logic [15:0] OFS_PRIMARY_ADDR_FIRST    = 16'h81c0;
   localparam logic [15:0] OFS_PRIMARY_ADDR_SECOND   = 16'h81c4;
   localparam logic [15:0] OFS_PRIMARY_STRIDE        = 16'h81c8;
   localparam logic [15:0] OFS_SELECT_CONTROL        = 16'h81cc;
   localparam logic [15:0] OFS_SECONDARY_ADDR_FIRST  = 16'h81d0;
   localparam logic [15:0] OFS_SECONDARY_ADDR_SECOND = 16'h81d4;
   localparam logic [15:0] OFS_SECONDARY_STRIDE      = 16'h81d8;
   localparam logic [15:0] OFS_INPUT_ADDR_FIRST      = 16'h81e0;
   localparam logic [15:0] OFS_INPUT_ADDR_SECOND     = 16'h81e4;
   localparam int          ADDR_W                    = 22;
   localparam int          STRIDE_W                  = 12;
   localparam int          BIT_PRIMARY_CHOICE        = 0;
   localparam int          BIT_SECONDARY_LO          = 1;
   localparam int          BIT_INPUT_CHOICE          = 4;
   localparam int          BIT_LOAD_TIMING           = 5;
   localparam int          BIT_AUTO_FLIP             = 6;
   localparam logic [1:0]  SEC_FIRST                 = 2'h0;
   localparam logic [1:0]  SEC_SECOND                = 2'h1;
   localparam logic [1:0]  SEC_FOLLOW_INPUT          = 2'h2;
   localparam logic [1:0]  SEC_OPPOSE_INPUT          = 2'h3;
   localparam logic [21:0] RESET_ADDR                = 22'h000000;
   localparam logic [11:0] RESET_STRIDE              = 12'h000;
endpackage : stream_buffer_pkg

/* File: verilog/stream_buffer_address_select.sv */
// Start address, stride and double buffer selection registers for two display
// streams and the video input writer, reached over APB.
// Assumes frame end and vertical sync arrive as one-cycle pulses on the system clock.
//
// Behaviour
// - Hold 22-bit second primary start address; upper bits read zero.
// - Hold 22-bit first primary start address in its own register.
// - Hold first and second 22-bit secondary start addresses.
// - Primary 12-bit stride steps lines of the primary buffer.
// - Secondary 12-bit stride steps lines of the secondary buffer.
// - Primary choice bit 0 picks first or second primary address.
// - Secondary field 00 or 01 picks first or second address.
// - Secondary field 10 follows the input port's current buffer index.
// - Secondary field 11 takes the buffer opposite to the input port's.
// - Input choice bit 4 picks input address first or second.
// - Load timing 0 applies input choice now, 1 at next frame end.
// - Auto flip inverts input choice at each frame end that has no deferred choice pending and no control write in the same cycle.
// - Frame end means all words of an input frame are written.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
module stream_buffer_address_select
(
   input  wire logic        i_sys_clk,
   input  wire logic        i_rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [15:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        i_vsync,
   input  wire logic        i_input_frame_done,
   output logic      [21:0] o_primary_start,
   output logic      [11:0] o_primary_stride,
   output logic      [21:0] o_secondary_start,
   output logic      [11:0] o_secondary_stride,
   output logic      [21:0] o_input_start,
   output logic             o_input_buffer_index
);

   ////////////////////////////////////////////////////////////////////////////
   logic [21:0] primary_addr_first;
   logic [21:0] primary_addr_second;
   logic [21:0] secondary_addr_first;
   logic [21:0] secondary_addr_second;
   logic [21:0] input_addr_first;
   logic [21:0] input_addr_second;
   logic [11:0] primary_stride;
   logic [11:0] secondary_stride;
   logic        primary_buffer_choice;
   logic [1:0]  secondary_buffer_choice;
   logic        input_choice_written;
   logic        input_choice_load_timing;
   logic        input_choice_auto_flip;
   logic        input_port_buffer_choice;
   logic        input_choice_pending;
   logic        wr_en;
   logic        rd_en;
   logic        hit;
   logic [31:0] rd_word;
   logic        next_secondary_index;

   function automatic logic [21:0] pick(input logic sel, input logic [21:0] a0,
                                        input logic [21:0] a1);
      pick = sel ? a1 : a0;
   endfunction : pick

   ////////////////////////////////////////////////////////////////////////////
   // Zero wait state slave: each access phase completes in its first cycle.
   assign wr_en = psel && penable && pwrite && pready;
   assign rd_en = psel && !penable && !pwrite;

   always_comb
   begin
      hit     = 1'b1;
      rd_word = 32'h00000000;
      case (paddr)
         stream_buffer_pkg::OFS_PRIMARY_ADDR_FIRST:    rd_word[21:0] = primary_addr_first;
         stream_buffer_pkg::OFS_PRIMARY_ADDR_SECOND:   rd_word[21:0] = primary_addr_second;
         stream_buffer_pkg::OFS_PRIMARY_STRIDE:        rd_word[11:0] = primary_stride;
         stream_buffer_pkg::OFS_SELECT_CONTROL:
         begin
            rd_word[stream_buffer_pkg::BIT_PRIMARY_CHOICE] = primary_buffer_choice;
            rd_word[2:1]                                   = secondary_buffer_choice;
            rd_word[stream_buffer_pkg::BIT_INPUT_CHOICE]   = input_port_buffer_choice;
            rd_word[stream_buffer_pkg::BIT_LOAD_TIMING]    = input_choice_load_timing;
            rd_word[stream_buffer_pkg::BIT_AUTO_FLIP]      = input_choice_auto_flip;
         end
         stream_buffer_pkg::OFS_SECONDARY_ADDR_FIRST:  rd_word[21:0] = secondary_addr_first;
         stream_buffer_pkg::OFS_SECONDARY_ADDR_SECOND: rd_word[21:0] = secondary_addr_second;
         stream_buffer_pkg::OFS_SECONDARY_STRIDE:      rd_word[11:0] = secondary_stride;
         stream_buffer_pkg::OFS_INPUT_ADDR_FIRST:      rd_word[21:0] = input_addr_first;
         stream_buffer_pkg::OFS_INPUT_ADDR_SECOND:     rd_word[21:0] = input_addr_second;
         default:                                      hit = 1'b0;
      endcase
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end
      else
      begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !hit;
         if (rd_en)
         begin
            prdata <= rd_word;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Address and stride storage; bits above each field are dropped on write.
   // The low three address bits are kept as written: software keeps them zero so
   // that each buffer starts on a quadword boundary, and nothing here rounds them.
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         primary_addr_first    <= stream_buffer_pkg::RESET_ADDR;
         primary_addr_second   <= stream_buffer_pkg::RESET_ADDR;
         secondary_addr_first  <= stream_buffer_pkg::RESET_ADDR;
         secondary_addr_second <= stream_buffer_pkg::RESET_ADDR;
         input_addr_first      <= stream_buffer_pkg::RESET_ADDR;
         input_addr_second     <= stream_buffer_pkg::RESET_ADDR;
         primary_stride        <= stream_buffer_pkg::RESET_STRIDE;
         secondary_stride      <= stream_buffer_pkg::RESET_STRIDE;
      end
      else if (wr_en)
      begin
         case (paddr)
            stream_buffer_pkg::OFS_PRIMARY_ADDR_FIRST:    primary_addr_first    <= pwdata[21:0];
            stream_buffer_pkg::OFS_PRIMARY_ADDR_SECOND:   primary_addr_second   <= pwdata[21:0];
            stream_buffer_pkg::OFS_SECONDARY_ADDR_FIRST:  secondary_addr_first  <= pwdata[21:0];
            stream_buffer_pkg::OFS_SECONDARY_ADDR_SECOND: secondary_addr_second <= pwdata[21:0];
            stream_buffer_pkg::OFS_INPUT_ADDR_FIRST:      input_addr_first      <= pwdata[21:0];
            stream_buffer_pkg::OFS_INPUT_ADDR_SECOND:     input_addr_second     <= pwdata[21:0];
            stream_buffer_pkg::OFS_PRIMARY_STRIDE:        primary_stride        <= pwdata[11:0];
            stream_buffer_pkg::OFS_SECONDARY_STRIDE:      secondary_stride      <= pwdata[11:0];
            default:
            begin
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Selection control. A pending deferred write takes priority over the flip
   // at the same frame end, so software's explicit choice is not undone at that frame end.
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         primary_buffer_choice    <= 1'b0;
         secondary_buffer_choice  <= stream_buffer_pkg::SEC_FIRST;
         input_choice_load_timing <= 1'b0;
         input_choice_auto_flip   <= 1'b0;
         input_choice_written     <= 1'b0;
         input_choice_pending     <= 1'b0;
         input_port_buffer_choice <= 1'b0;
      end
      else
      begin
         if (wr_en && paddr == stream_buffer_pkg::OFS_SELECT_CONTROL)
         begin
            primary_buffer_choice    <= pwdata[stream_buffer_pkg::BIT_PRIMARY_CHOICE];
            secondary_buffer_choice  <= pwdata[2:1];
            input_choice_load_timing <= pwdata[stream_buffer_pkg::BIT_LOAD_TIMING];
            input_choice_auto_flip   <= pwdata[stream_buffer_pkg::BIT_AUTO_FLIP];
            if (!pwdata[stream_buffer_pkg::BIT_LOAD_TIMING])
            begin
               input_port_buffer_choice <= pwdata[stream_buffer_pkg::BIT_INPUT_CHOICE];
               input_choice_pending     <= 1'b0;
            end
            else
            begin
               input_choice_written <= pwdata[stream_buffer_pkg::BIT_INPUT_CHOICE];
               input_choice_pending <= 1'b1;
            end
         end
         else if (i_input_frame_done)
         begin
            if (input_choice_pending)
            begin
               input_port_buffer_choice <= input_choice_written;
               input_choice_pending     <= 1'b0;
            end
            else if (input_choice_auto_flip)
            begin
               input_port_buffer_choice <= !input_port_buffer_choice;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      case (secondary_buffer_choice)
         stream_buffer_pkg::SEC_FIRST:        next_secondary_index = 1'b0;
         stream_buffer_pkg::SEC_SECOND:       next_secondary_index = 1'b1;
         stream_buffer_pkg::SEC_FOLLOW_INPUT: next_secondary_index = input_port_buffer_choice;
         stream_buffer_pkg::SEC_OPPOSE_INPUT: next_secondary_index = !input_port_buffer_choice;
         default:                             next_secondary_index = 1'b0;
      endcase
   end

   // Display outputs change only at vsync so a frame never mixes two buffers.
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         o_primary_start    <= stream_buffer_pkg::RESET_ADDR;
         o_secondary_start  <= stream_buffer_pkg::RESET_ADDR;
         o_primary_stride   <= stream_buffer_pkg::RESET_STRIDE;
         o_secondary_stride <= stream_buffer_pkg::RESET_STRIDE;
      end
      else if (i_vsync)
      begin
         o_primary_start    <= pick(primary_buffer_choice, primary_addr_first,
                                    primary_addr_second);
         o_secondary_start  <= pick(next_secondary_index, secondary_addr_first,
                                    secondary_addr_second);
         o_primary_stride   <= primary_stride;
         o_secondary_stride <= secondary_stride;
      end
   end

   // The writer reads the input start each frame, so it follows the choice at once.
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         o_input_start        <= stream_buffer_pkg::RESET_ADDR;
         o_input_buffer_index <= 1'b0;
      end
      else
      begin
         o_input_start        <= pick(input_port_buffer_choice, input_addr_first,
                                      input_addr_second);
         o_input_buffer_index <= input_port_buffer_choice;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Input choice. A frame end with a pending deferred value and no control write loads it and skips
   // the flip; any other frame end flips the choice only when auto flip is set.
   a_flip_on_end: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (i_input_frame_done && input_choice_auto_flip && !input_choice_pending && !wr_en)
      |=> input_port_buffer_choice != $past(input_port_buffer_choice))
      else $error("input choice did not flip at frame end");
   a_hold_no_flip: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (!wr_en && !(i_input_frame_done && (input_choice_auto_flip || input_choice_pending)))
      |=> $stable(input_port_buffer_choice))
      else $error("input choice changed without cause");
   a_deferred_load: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (i_input_frame_done && input_choice_pending && !wr_en)
      |=> input_port_buffer_choice == $past(input_choice_written))
      else $error("deferred input choice not applied");
   a_deferred_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (wr_en && paddr == stream_buffer_pkg::OFS_SELECT_CONTROL
       && pwdata[stream_buffer_pkg::BIT_LOAD_TIMING])
      |=> $stable(input_port_buffer_choice) && input_choice_pending)
      else $error("deferred input choice applied too early");
   a_immediate_load: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (wr_en && paddr == stream_buffer_pkg::OFS_SELECT_CONTROL
       && !pwdata[stream_buffer_pkg::BIT_LOAD_TIMING])
      |=> input_port_buffer_choice == $past(pwdata[stream_buffer_pkg::BIT_INPUT_CHOICE]))
      else $error("immediate input choice not applied");
   a_input_start: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      ##1 o_input_start == ($past(input_port_buffer_choice) ? $past(input_addr_second)
                                                          : $past(input_addr_first)))
      else $error("input start address wrong");
   a_input_index: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      ##1 o_input_buffer_index == $past(input_port_buffer_choice))
      else $error("input buffer index wrong");

   ////////////////////////////////////////////////////////////////////////////
   // Display side. Every output moves only on vsync, and then to the buffer
   // that the select fields name at that moment.
   a_primary_pick: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      i_vsync |=> o_primary_start == ($past(primary_buffer_choice)
                  ? $past(primary_addr_second) : $past(primary_addr_first)))
      else $error("primary start address wrong");
   a_secondary_fixed: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (i_vsync && !secondary_buffer_choice[1])
      |=> o_secondary_start == ($past(secondary_buffer_choice[0])
          ? $past(secondary_addr_second) : $past(secondary_addr_first)))
      else $error("secondary fixed choice wrong");
   a_secondary_follow: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (i_vsync && secondary_buffer_choice == stream_buffer_pkg::SEC_FOLLOW_INPUT)
      |=> o_secondary_start == ($past(input_port_buffer_choice)
          ? $past(secondary_addr_second) : $past(secondary_addr_first)))
      else $error("secondary does not follow input");
   a_secondary_oppose: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (i_vsync && secondary_buffer_choice == stream_buffer_pkg::SEC_OPPOSE_INPUT)
      |=> o_secondary_start == ($past(input_port_buffer_choice)
          ? $past(secondary_addr_first) : $past(secondary_addr_second)))
      else $error("secondary does not oppose input");
   a_stride_latch: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      i_vsync |=> o_primary_stride == $past(primary_stride)
                  && o_secondary_stride == $past(secondary_stride))
      else $error("stride not latched at vsync");
   a_display_stable: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      !i_vsync |=> $stable(o_primary_start) && $stable(o_secondary_start)
                   && $stable(o_primary_stride) && $stable(o_secondary_stride))
      else $error("display output changed outside vsync");

   ////////////////////////////////////////////////////////////////////////////
   // Register storage and bus answers. Only the low field bits are kept, so a
   // stray reserved bit never reaches a fetch engine as part of an address.
   a_store_second: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (wr_en && paddr == stream_buffer_pkg::OFS_PRIMARY_ADDR_SECOND)
      |=> primary_addr_second == $past(pwdata[21:0]))
      else $error("primary second address not stored");
   a_store_first: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (wr_en && paddr == stream_buffer_pkg::OFS_PRIMARY_ADDR_FIRST)
      |=> primary_addr_first == $past(pwdata[21:0]))
      else $error("primary first address not stored");
   a_store_secondary: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (wr_en && paddr == stream_buffer_pkg::OFS_SECONDARY_ADDR_FIRST)
      |=> secondary_addr_first == $past(pwdata[21:0]))
      else $error("secondary first address not stored");
   a_store_sec_second: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (wr_en && paddr == stream_buffer_pkg::OFS_SECONDARY_ADDR_SECOND)
      |=> secondary_addr_second == $past(pwdata[21:0]))
      else $error("secondary second address not stored");
   a_store_stride: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (wr_en && paddr == stream_buffer_pkg::OFS_PRIMARY_STRIDE)
      |=> primary_stride == $past(pwdata[11:0]))
      else $error("primary stride not stored");
   a_apb_ready: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (psel && !penable) |=> pready ##1 !pready)
      else $error("apb ready not one cycle after setup");
   a_unmapped_error: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (psel && !penable && !hit) |=> pslverr && pready)
      else $error("unmapped access without error");

endmodule : stream_buffer_address_select

/* File: testbench/stream_buffer_address_select_test.sv */
// Self-checking bench for the stream buffer address block: register rows, selection modes,
// deferred and flipping input choice, and resets. Assumes the design package is compiled first.
`timescale 1ns/1ps
module stream_buffer_address_select_test;
   typedef struct packed {logic [15:0] a; logic [31:0] w; logic [31:0] r; logic e;} row_t;
   logic        i_sys_clk = 1'b0;
   logic        i_rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [15:0] paddr = 16'h0000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        i_vsync = 1'b0;
   logic        i_input_frame_done = 1'b0;
   logic [21:0] o_primary_start;
   logic [11:0] o_primary_stride;
   logic [21:0] o_secondary_start;
   logic [11:0] o_secondary_stride;
   logic [21:0] o_input_start;
   logic        o_input_buffer_index;
   int          errors = 0;
   int          n_tests = 0;
   logic [21:0] prev_p;
   logic [21:0] exp_p;
   logic        si;
   logic        icb;
   localparam logic [15:0] CTRL = stream_buffer_pkg::OFS_SELECT_CONTROL;
   row_t rows [0:17] = '{
      '{16'h81c0, 32'hfffffff8, 32'h003ffff8, 1'b0}, '{16'h81c4, 32'hfffffff8, 32'h003ffff8, 1'b0},
      '{16'h81c8, 32'hffffffff, 32'h00000fff, 1'b0}, '{16'h81cc, 32'hffffffcf, 32'h00000047, 1'b0},
      '{16'h81d0, 32'hfffffff8, 32'h003ffff8, 1'b0}, '{16'h81d4, 32'hfffffff8, 32'h003ffff8, 1'b0},
      '{16'h81d8, 32'hffffffff, 32'h00000fff, 1'b0}, '{16'h81e0, 32'hfffffff8, 32'h003ffff8, 1'b0},
      '{16'h81e4, 32'hfffffff8, 32'h003ffff8, 1'b0}, '{16'h8200, 32'hffffffff, 32'h00000000, 1'b1},
      '{16'h81c0, 32'h00000100, 32'h00000100, 1'b0}, '{16'h81c4, 32'h00000200, 32'h00000200, 1'b0},
      '{16'h81d0, 32'h00000300, 32'h00000300, 1'b0}, '{16'h81d4, 32'h00000400, 32'h00000400, 1'b0},
      '{16'h81c8, 32'h00000123, 32'h00000123, 1'b0}, '{16'h81d8, 32'h00000456, 32'h00000456, 1'b0},
      '{16'h81e0, 32'h00000500, 32'h00000500, 1'b0}, '{16'h81e4, 32'h00000600, 32'h00000600, 1'b0}};

   always #2.5 i_sys_clk = ~i_sys_clk;

   stream_buffer_address_select u_dut
   (
      .i_sys_clk(i_sys_clk), .i_rst(i_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .i_vsync(i_vsync), .i_input_frame_done(i_input_frame_done),
      .o_primary_start(o_primary_start), .o_primary_stride(o_primary_stride),
      .o_secondary_start(o_secondary_start), .o_secondary_stride(o_secondary_stride),
      .o_input_start(o_input_start), .o_input_buffer_index(o_input_buffer_index)
   );

   ////////////////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         errors++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic results;
      if (errors == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : results

   // The request is held until pready is seen at a rising edge; a wait longer than one cycle is counted as an error.
   task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
      int n;
      @(posedge i_sys_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge i_sys_clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge i_sys_clk);
         n++;
      end
      while (pready !== 1'b1);
      check("pready_wait", 32'(n), 32'h00000001);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
   endtask : wr

   task automatic rd(input logic [15:0] a, input logic [31:0] exp, input logic exp_e);
      logic [31:0] q;
      logic        e;
      apb(1'b0, a, 32'h00000000, q, e);
      check("prdata", q, exp);
      check("pslverr", 32'(e), 32'(exp_e));
   endtask : rd

   // Sync pulses are one cycle wide; outputs are looked at once they have settled.
   task automatic pulse(input logic vs);
      @(posedge i_sys_clk);
      i_vsync <= vs;
      i_input_frame_done <= ~vs;
      @(posedge i_sys_clk);
      i_vsync <= 1'b0;
      i_input_frame_done <= 1'b0;
      repeat (2) @(posedge i_sys_clk);
      #1;
   endtask : pulse

   task automatic settle;
      repeat (3) @(posedge i_sys_clk);
      #1;
   endtask : settle

   ////////////////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      #50000;
      errors++;
      results();
   end

   initial
   begin
      repeat (5) @(posedge i_sys_clk);
      i_rst <= 1'b0;
      settle();
      check("o_primary_start", 32'(o_primary_start), 32'h00000000);
      check("o_input_buffer_index", 32'(o_input_buffer_index), 32'h00000000);
      for (int i = 0; i < 9; i++)
         rd(rows[i].a, 32'h00000000, 1'b0);
      for (int i = 0; i < 18; i++)
      begin
         wr(rows[i].a, rows[i].w);
         rd(rows[i].a, rows[i].r, rows[i].e);
      end
      wr(CTRL, 32'h00000000);
      pulse(1'b1);
      prev_p = 22'h000100;
      for (int p = 0; p < 2; p++)
         for (int s = 0; s < 4; s++)
            for (int ic = 0; ic < 2; ic++)
            begin
               icb = ic[0];
               si = (s == 0) ? 1'b0 : (s == 1) ? 1'b1 : (s == 2) ? icb : ~icb;
               exp_p = (p == 1) ? 22'h000200 : 22'h000100;
               wr(CTRL, 32'((ic << 4) | (s << 1) | p));
               settle();
               check("o_primary_start", 32'(o_primary_start), 32'(prev_p));
               check("o_input_start", 32'(o_input_start), icb ? 32'h600 : 32'h500);
               pulse(1'b1);
               check("o_primary_start", 32'(o_primary_start), 32'(exp_p));
               check("o_secondary_start", 32'(o_secondary_start), si ? 32'h400 : 32'h300);
               check("o_primary_stride", 32'(o_primary_stride), 32'h00000123);
               check("o_secondary_stride", 32'(o_secondary_stride), 32'h00000456);
               prev_p = exp_p;
            end
      wr(CTRL, 32'h00000000);
      wr(CTRL, 32'h00000030);
      settle();
      check("o_input_buffer_index", 32'(o_input_buffer_index), 32'h00000000);
      rd(CTRL, 32'h00000020, 1'b0);
      pulse(1'b0);
      check("o_input_buffer_index", 32'(o_input_buffer_index), 32'h00000001);
      check("o_input_start", 32'(o_input_start), 32'h00000600);
      wr(CTRL, 32'h00000050);
      pulse(1'b0);
      check("o_input_buffer_index", 32'(o_input_buffer_index), 32'h00000000);
      pulse(1'b0);
      check("o_input_buffer_index", 32'(o_input_buffer_index), 32'h00000001);
      wr(CTRL, 32'h00000010);
      pulse(1'b0);
      check("o_input_buffer_index", 32'(o_input_buffer_index), 32'h00000001);
      wr(CTRL, 32'h00000060);
      pulse(1'b0);
      check("o_input_buffer_index", 32'(o_input_buffer_index), 32'h00000000);
      pulse(1'b0);
      check("o_input_buffer_index", 32'(o_input_buffer_index), 32'h00000001);
      @(posedge i_sys_clk);
      i_rst <= 1'b1;
      repeat (2) @(posedge i_sys_clk);
      i_rst <= 1'b0;
      settle();
      check("o_input_buffer_index", 32'(o_input_buffer_index), 32'h00000000);
      rd(CTRL, 32'h00000000, 1'b0);
      rd(16'h81c4, 32'h00000000, 1'b0);
      results();
   end
endmodule : stream_buffer_address_select_test
